// file: src/port_cfg_map.svh
`ifndef PORT_CFG_MAP_SVH
`define PORT_CFG_MAP_SVH

// ********************************************************************
// Register byte offsets inside the port configuration space.
// ********************************************************************
`define MSI_CTL_OFS 12'h0d0
`define MSI_LO_OFS 12'h0d4
`define MSI_HI_OFS 12'h0d8
`define MSI_PAYLOAD_OFS 12'h0dc
`define SS_CAP_OFS 12'h0f0
`define SS_IDENT_OFS 12'h0f4
`define IND_PTR_OFS 12'h0f8
`define IND_WIN_OFS 12'h0fc

// ********************************************************************
// Constant field values and reset values.
// ********************************************************************
`define MSI_CAP_CODE 8'h05
`define SS_CAP_CODE 8'h0d
`define NEXT_LINK_RST 8'h00
`define MSI_EN_RST 1'b0
`define MSI_EN_BIT 16
`define MSI_A64_BIT 23
`define WORD_RST 32'h0000_0000

// ********************************************************************
// Field positions of the indirect pointer.
// ********************************************************************
`define PTR_DW_LSB 2
`define PTR_PAGE_LSB 8

`endif

// file: src/port_cfg_pkg.sv
package port_cfg_pkg;

    // Architectural contents of the register bank plus the access answer.
    typedef struct packed {
        logic msi_en;
        logic [7:0] msi_next;
        logic [29:0] msi_lo;
        logic [31:0] msi_hi;
        logic [15:0] payload;
        logic [7:0] ss_next;
        logic [31:0] ss_ident;
        logic [5:0] ptr_dw;
        logic [3:0] ptr_page;
        logic [31:0] rdata;
        logic ack;
    } bank_state_t;

    // Interrupt write request being offered upstream.
    typedef struct packed {
        logic valid;
        logic is64;
        logic [63:0] addr;
        logic [15:0] data;
        logic pend;
    } msi_state_t;

endpackage

// file: src/msi_issuer.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg_map.svh"

module msi_issuer
    import port_cfg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic fire,
    input wire logic en,
    input wire logic [29:0] lo,
    input wire logic [31:0] hi,
    input wire logic [15:0] payload,
    input wire logic ready,
    output logic valid,
    output logic is64,
    output logic [63:0] addr,
    output logic [31:0] data
);
    msi_state_t s_q, s_d;

    // ****************************************************************
    // Request capture and hand-off.
    // ****************************************************************

    // A trigger that lands while a request is still waiting is kept as
    // pending; only one is held, so further triggers while it waits merge into it.
    always_comb begin
        s_d = s_q;
        if (s_q.valid && ready) begin
            s_d.valid = 1'b0;
        end
        if (!en) begin
            s_d.pend = 1'b0;
        end else if ((fire || s_q.pend) && !s_d.valid) begin
            s_d.valid = 1'b1;
            s_d.pend = 1'b0;
            s_d.is64 = (hi != 32'h0000_0000);
            s_d.addr = (hi != 32'h0000_0000) ? {hi, lo, 2'b00} : {32'h0000_0000, lo, 2'b00};
            s_d.data = payload;
        end else if (fire) begin
            s_d.pend = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // The address is passed on unchanged; the request leaves only on the
    // upstream-facing port, so software must aim it at the root.
    assign valid = s_q.valid;
    assign is64 = s_q.is64;
    assign addr = s_q.addr;
    assign data = {16'h0000, s_q.data};

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_wide_addr;
        @(posedge sys_clk) disable iff (!rst_b)
        valid |-> (is64 == (addr[63:32] != 32'h0000_0000));
    endproperty
    a_wide_addr: assert property (p_wide_addr) else $error("address width flag wrong");

    property p_data_top;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(valid) |-> data[31:16] == 16'h0000 && data[15:0] == $past(payload);
    endproperty
    a_data_top: assert property (p_data_top) else $error("interrupt data wrong");

    property p_only_enabled;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(valid) |-> $past(en);
    endproperty
    a_only_enabled: assert property (p_only_enabled) else $error("interrupt while off");
endmodule

`default_nettype wire

// file: src/port_msi_subsystem_code_indirect_cfg_regs.sv
// Functional notes
// - A non-zero upper target makes the interrupt write use a 64-bit address, else 32-bit.
// - Interrupt writes leave toward the upstream port and software must aim them there.
// - The 16-bit payload gives the low data half; payload bits 31:16 read zero.
// - The subsystem header returns code 0xD, a next link resetting to 0x00, upper half zero.
// - The subsystem word holds maker code low and subsystem code high, lock-writable, reset 0.
// - The indirect pointer holds dword index 7:2 and page index 11:8; other bits read zero.
// - A read of the window returns the register that the pointer selects.
// - A write of the window writes the register that the pointer selects.
// - Indirect accesses use the byte enables of the window access.
// - With the pointer on the window itself, window reads give zero and writes are dropped.
// - With the pointer on itself, a window write changes the pointer.
// - Window accesses from the management path read zero and write nothing.
// - The lower target holds bits 31:2 of the dword-aligned address; bits 1:0 are zero.
// - Interrupt requests are raised only while enable bit 16 of the control word is set; reset off.
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg_map.svh"

module port_msi_subsystem_code_indirect_cfg_regs
    import port_cfg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic cfg_mgmt,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_unlock,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic msi_fire,
    input wire logic upstream_msi_ready,
    output logic upstream_msi_valid,
    output logic upstream_msi_is64,
    output logic [63:0] upstream_msi_addr,
    output logic [31:0] upstream_msi_data
);
    bank_state_t s_q, s_d;
    logic [9:0] ptr_idx;
    logic [9:0] req_idx;

    // ****************************************************************
    // Shared decode helpers.
    // ****************************************************************

    // Contents of one register as a configuration read sees it.
    function automatic logic [31:0] read_reg(bank_state_t s, logic [9:0] idx);
        logic [31:0] v;
        v = `WORD_RST;
        case ({idx, 2'b00})
            `MSI_CTL_OFS: begin
                v[7:0] = `MSI_CAP_CODE;
                v[15:8] = s.msi_next;
                v[`MSI_EN_BIT] = s.msi_en;
                v[`MSI_A64_BIT] = 1'b1;
            end
            `MSI_LO_OFS: v = {s.msi_lo, 2'b00};
            `MSI_HI_OFS: v = s.msi_hi;
            `MSI_PAYLOAD_OFS: v = {16'h0000, s.payload};
            `SS_CAP_OFS: v = {16'h0000, s.ss_next, `SS_CAP_CODE};
            `SS_IDENT_OFS: v = s.ss_ident;
            `IND_PTR_OFS: v = {20'h00000, s.ptr_page, s.ptr_dw, 2'b00};
            default: v = `WORD_RST;
        endcase
        return v;
    endfunction

    // Store a byte-enabled write; lock-protected fields need the unlock.
    function automatic bank_state_t write_reg(bank_state_t s, logic [9:0] idx,
                                              logic [31:0] wd, logic [3:0] be,
                                              logic unlock);
        bank_state_t r;
        logic [31:0] m;
        r = s;
        m = read_reg(s, idx);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[8*b +: 8] = wd[8*b +: 8];
            end
        end
        case ({idx, 2'b00})
            `MSI_CTL_OFS: begin
                r.msi_en = m[`MSI_EN_BIT];
                if (unlock) begin
                    r.msi_next = m[15:8];
                end
            end
            `MSI_LO_OFS: r.msi_lo = m[31:2];
            `MSI_HI_OFS: r.msi_hi = m;
            `MSI_PAYLOAD_OFS: r.payload = m[15:0];
            `SS_CAP_OFS: begin
                if (unlock) begin
                    r.ss_next = m[15:8];
                end
            end
            `SS_IDENT_OFS: begin
                if (unlock) begin
                    r.ss_ident = m;
                end
            end
            `IND_PTR_OFS: begin
                r.ptr_dw = m[7:2];
                r.ptr_page = m[11:8];
            end
            default: r = s;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // Configuration access handling.
    // ****************************************************************
    assign ptr_idx = {s_q.ptr_page, s_q.ptr_dw};
    assign req_idx = cfg_addr[11:2];

    // Every request is answered on the next edge; the window is resolved
    // through the pointer, and the window never reaches itself, which
    // keeps the indirection from recursing.
    always_comb begin
        s_d = s_q;
        s_d.ack = cfg_req;
        s_d.rdata = `WORD_RST;
        if (cfg_req) begin
            if ({req_idx, 2'b00} == `IND_WIN_OFS) begin
                if (cfg_mgmt || {ptr_idx, 2'b00} == `IND_WIN_OFS) begin
                    s_d.rdata = `WORD_RST;
                end else if (cfg_wr) begin
                    s_d = write_reg(s_d, ptr_idx, cfg_wdata, cfg_be, cfg_unlock);
                end else begin
                    s_d.rdata = read_reg(s_q, ptr_idx);
                end
            end else if (cfg_wr) begin
                s_d = write_reg(s_d, req_idx, cfg_wdata, cfg_be, cfg_unlock);
            end else begin
                s_d.rdata = read_reg(s_q, req_idx);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.msi_en <= `MSI_EN_RST;
            s_q.ss_next <= `NEXT_LINK_RST;
            s_q.msi_next <= `NEXT_LINK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_rdata = s_q.rdata;
    assign cfg_ack = s_q.ack;

    // ****************************************************************
    // Interrupt write generation.
    // ****************************************************************
    msi_issuer u_issuer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .fire(msi_fire),
        .en(s_q.msi_en),
        .lo(s_q.msi_lo),
        .hi(s_q.msi_hi),
        .payload(s_q.payload),
        .ready(upstream_msi_ready),
        .valid(upstream_msi_valid),
        .is64(upstream_msi_is64),
        .addr(upstream_msi_addr),
        .data(upstream_msi_data)
    );

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_win_self;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && !cfg_wr && {req_idx, 2'b00} == `IND_WIN_OFS
            && {ptr_idx, 2'b00} == `IND_WIN_OFS |=> cfg_ack && cfg_rdata == 32'h0;
    endproperty
    a_win_self: assert property (p_win_self) else $error("self window read not zero");

    property p_mgmt_read;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && !cfg_wr && cfg_mgmt && {req_idx, 2'b00} == `IND_WIN_OFS
            |=> cfg_rdata == 32'h0;
    endproperty
    a_mgmt_read: assert property (p_mgmt_read) else $error("management read not zero");

    property p_mgmt_write;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && cfg_wr && cfg_mgmt && {req_idx, 2'b00} == `IND_WIN_OFS
            |=> $stable(s_q.msi_hi) && $stable(s_q.payload) && $stable(ptr_idx);
    endproperty
    a_mgmt_write: assert property (p_mgmt_write) else $error("management write took effect");

    property p_ptr_self;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && cfg_wr && !cfg_mgmt && cfg_be[1:0] == 2'b11
            && {req_idx, 2'b00} == `IND_WIN_OFS && {ptr_idx, 2'b00} == `IND_PTR_OFS
            |=> ptr_idx == $past(cfg_wdata[11:2]);
    endproperty
    a_ptr_self: assert property (p_ptr_self) else $error("pointer not rewritten");

    property p_ind_write;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && cfg_wr && !cfg_mgmt && cfg_be == 4'b0001
            && {req_idx, 2'b00} == `IND_WIN_OFS && {ptr_idx, 2'b00} == `MSI_PAYLOAD_OFS
            |=> s_q.payload == {$past(s_q.payload[15:8]), $past(cfg_wdata[7:0])};
    endproperty
    a_ind_write: assert property (p_ind_write) else $error("indirect lane write wrong");

    property p_ind_read;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && !cfg_wr && !cfg_mgmt
            && {req_idx, 2'b00} == `IND_WIN_OFS && {ptr_idx, 2'b00} == `MSI_PAYLOAD_OFS
            |=> cfg_rdata == {16'h0000, $past(s_q.payload)};
    endproperty
    a_ind_read: assert property (p_ind_read) else $error("indirect read wrong");

    property p_ptr_rsv;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && !cfg_wr && {req_idx, 2'b00} == `IND_PTR_OFS
            |=> cfg_rdata[1:0] == 2'b00 && cfg_rdata[31:12] == 20'h00000;
    endproperty
    a_ptr_rsv: assert property (p_ptr_rsv) else $error("pointer reserved bits set");

    property p_cap_hdr;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && !cfg_wr && {req_idx, 2'b00} == `SS_CAP_OFS
            |=> cfg_rdata[7:0] == 8'h0d && cfg_rdata[31:16] == 16'h0000;
    endproperty
    a_cap_hdr: assert property (p_cap_hdr) else $error("subsystem header wrong");

    property p_locked;
        @(posedge sys_clk) disable iff (!rst_b)
        cfg_req && cfg_wr && !cfg_unlock && {req_idx, 2'b00} == `SS_IDENT_OFS
            |=> $stable(s_q.ss_ident);
    endproperty
    a_locked: assert property (p_locked) else $error("locked word changed");
endmodule

`default_nettype wire

// file: tb/msi_sink_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// Upstream sink for interrupt writes, able to stall a chosen number of cycles.
// ********************************************************************
module msi_sink_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic valid,
    input wire logic is64,
    input wire logic [63:0] addr,
    input wire logic [31:0] data,
    input wire logic [3:0] stall,
    output logic ready,
    output logic [3:0] n_got,
    output logic [96:0] got,
    output logic moved
);
    logic [3:0] wait_q;
    logic [96:0] held_q;
    logic hold_q;

    // Accept only after the stall count, as a busy upstream port would.
    assign ready = valid && (wait_q >= stall);

    // Take each message on acceptance; flag any change while it waits.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 4'h0;
            n_got <= 4'h0;
            got <= '0;
            held_q <= '0;
            hold_q <= 1'b0;
            moved <= 1'b0;
        end else begin
            if (hold_q && valid && ({is64, addr, data} !== held_q)) begin
                moved <= 1'b1;
            end
            held_q <= {is64, addr, data};
            hold_q <= valid && !ready;
            if (valid && ready) begin
                wait_q <= 4'h0;
                n_got <= n_got + 4'h1;
                got <= {is64, addr, data};
            end else if (valid) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

`default_nettype wire

// file: tb/port_msi_subsystem_code_indirect_cfg_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end

module port_msi_subsystem_code_indirect_cfg_regs_tb;
    import port_cfg_pkg::*;

    typedef struct packed {
        logic wr;
        logic mg;
        logic [11:0] a;
        logic [3:0] be;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;

    logic sys_clk, rst_b, cfg_req, cfg_wr, cfg_mgmt, cfg_unlock, cfg_ack;
    logic [11:0] cfg_addr;
    logic [3:0] cfg_be, stall, n_got;
    logic [31:0] cfg_wdata, cfg_rdata, upstream_msi_data;
    logic msi_fire, upstream_msi_ready, upstream_msi_valid, upstream_msi_is64, moved;
    logic [63:0] upstream_msi_addr;
    logic [96:0] got;
    int err_count, n_checks, cyc;

    // ****************************************************************
    // Direct, window and management accesses: writes expect zero read data, reads the value.
    // ****************************************************************
    localparam row_t ROWS [0:29] = '{
        '{0, 0, 12'h0d0, 4'hf, 32'h0, 32'h0080_0005},
        '{0, 0, 12'h0f0, 4'hf, 32'h0, 32'h0000_000d},
        '{0, 0, 12'h0d8, 4'hf, 32'h0, 32'h0},
        '{0, 0, 12'h0dc, 4'hf, 32'h0, 32'h0},
        '{0, 0, 12'h0f4, 4'hf, 32'h0, 32'h0},
        '{0, 0, 12'h0f8, 4'hf, 32'h0, 32'h0},
        '{1, 0, 12'h0d8, 4'hf, 32'hffff_ffff, 32'h0},
        '{0, 0, 12'h0d8, 4'hf, 32'h0, 32'hffff_ffff},
        '{1, 0, 12'h0dc, 4'hf, 32'ha5a5_1234, 32'h0},
        '{0, 0, 12'h0dc, 4'hf, 32'h0, 32'h0000_1234},
        '{1, 0, 12'h0f0, 4'hf, 32'hffff_ffff, 32'h0},
        '{0, 0, 12'h0f0, 4'hf, 32'h0, 32'h0000_ff0d},
        '{1, 0, 12'h0f4, 4'h3, 32'hdead_beef, 32'h0},
        '{0, 0, 12'h0f4, 4'hf, 32'h0, 32'h0000_beef},
        '{1, 0, 12'h0f8, 4'hf, 32'hffff_ffff, 32'h0},
        '{0, 0, 12'h0f8, 4'hf, 32'h0, 32'h0000_0ffc},
        '{1, 0, 12'h0d4, 4'hf, 32'h1234_5677, 32'h0},
        '{0, 0, 12'h0d4, 4'hf, 32'h0, 32'h1234_5674},
        '{1, 0, 12'h0f8, 4'hf, 32'h0000_00dc, 32'h0},
        '{1, 0, 12'h0fc, 4'h1, 32'h0000_5678, 32'h0},
        '{0, 0, 12'h0fc, 4'hf, 32'h0, 32'h0000_1278},
        '{1, 1, 12'h0fc, 4'hf, 32'hffff_ffff, 32'h0},
        '{0, 1, 12'h0fc, 4'hf, 32'h0, 32'h0},
        '{0, 0, 12'h0dc, 4'hf, 32'h0, 32'h0000_1278},
        '{1, 0, 12'h0f8, 4'hf, 32'h0000_00f8, 32'h0},
        '{1, 0, 12'h0fc, 4'hf, 32'h0000_00fc, 32'h0},
        '{0, 0, 12'h0fc, 4'hf, 32'h0, 32'h0},
        '{1, 0, 12'h0fc, 4'hf, 32'h0000_0000, 32'h0},
        '{0, 0, 12'h0f8, 4'hf, 32'h0, 32'h0000_00fc},
        '{0, 0, 12'h0dc, 4'hf, 32'h0, 32'h0000_1278}
    };

    port_msi_subsystem_code_indirect_cfg_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_mgmt(cfg_mgmt), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_unlock(cfg_unlock),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .msi_fire(msi_fire),
        .upstream_msi_ready(upstream_msi_ready), .upstream_msi_valid(upstream_msi_valid),
        .upstream_msi_is64(upstream_msi_is64), .upstream_msi_addr(upstream_msi_addr),
        .upstream_msi_data(upstream_msi_data));

    msi_sink_model sink_u (.sys_clk(sys_clk), .rst_b(rst_b), .valid(upstream_msi_valid),
        .is64(upstream_msi_is64), .addr(upstream_msi_addr), .data(upstream_msi_data),
        .stall(stall), .ready(upstream_msi_ready), .n_got(n_got), .got(got), .moved(moved));

    // Free-running 40 MHz clock.
    always #12.5 sys_clk = ~sys_clk;

    // Cuts a hang short; the ceiling is far above the hundred or so cycles needed.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            finish_test();
        end
    end

    // One access; request stays up so the next call runs back to back.
    task automatic acc(input row_t r);
        cfg_req = 1'b1;
        cfg_wr = r.wr;
        cfg_mgmt = r.mg;
        cfg_addr = r.a;
        cfg_be = r.be;
        cfg_wdata = r.d;
        @(posedge sys_clk);
        #2;
        `CHK("cfg_ack", 1'b1, cfg_ack)
        `CHK("cfg_rdata", r.e, cfg_rdata)
    endtask

    // Drop the request and let one idle edge pass; the answer pulse must be gone.
    task automatic idle();
        cfg_req = 1'b0;
        @(posedge sys_clk);
        #2;
        `CHK("ack_idle", 1'b0, cfg_ack)
    endtask

    // Pulse an interrupt request, then wait a fixed 12 cycles, longer than the stalls of 0 and 3 used here.
    // A fixed wait also catches a late message that should never have left.
    task automatic fire_msi(input logic [3:0] k);
        msi_fire = 1'b1;
        @(posedge sys_clk);
        #2;
        msi_fire = 1'b0;
        repeat (12) @(posedge sys_clk);
        #2;
        `CHK("n_got", k, n_got)
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        {sys_clk, rst_b, cfg_req, cfg_wr, cfg_mgmt, msi_fire} = '0;
        {cfg_addr, cfg_be, cfg_wdata, stall} = '0;
        cfg_unlock = 1'b1;
        repeat (2) @(posedge sys_clk);
        #2;
        rst_b = 1'b1;
        `CHK("ack_rst", 1'b0, cfg_ack)
        `CHK("valid_rst", 1'b0, upstream_msi_valid)
        foreach (ROWS[i]) acc(ROWS[i]);
        idle();
        // Locked fields must hold their value while the lock is closed.
        cfg_unlock = 1'b0;
        acc('{1, 0, 12'h0f4, 4'hf, 32'hffff_ffff, 32'h0});
        acc('{0, 0, 12'h0f4, 4'hf, 32'h0, 32'h0000_beef});
        idle();
        cfg_unlock = 1'b1;
        // A request while disabled must never reach the upstream side.
        fire_msi(4'h0);
        acc('{1, 0, 12'h0d0, 4'h4, 32'h0001_0000, 32'h0});
        idle();
        stall = 4'h3;
        fire_msi(4'h1);
        `CHK("msi64", {1'b1, 64'hffff_ffff_1234_5674, 32'h0000_1278}, got)
        `CHK("moved", 1'b0, moved)
        acc('{1, 0, 12'h0d8, 4'hf, 32'h0, 32'h0});
        idle();
        stall = 4'h0;
        fire_msi(4'h2);
        `CHK("msi32", {1'b0, 64'h0000_0000_1234_5674, 32'h0000_1278}, got)
        // Two requests in a row against a stalling sink: the second waits as pending.
        stall = 4'h3;
        msi_fire = 1'b1;
        @(posedge sys_clk);
        #2;
        fire_msi(4'h4);
        `CHK("msi_pend", {1'b0, 64'h0000_0000_1234_5674, 32'h0000_1278}, got)
        `CHK("moved_pend", 1'b0, moved)
        // Reset in mid-run must clear the payload, the link field and the pointer.
        rst_b = 1'b0;
        @(posedge sys_clk);
        #2;
        rst_b = 1'b1;
        `CHK("valid_rst2", 1'b0, upstream_msi_valid)
        acc('{0, 0, 12'h0dc, 4'hf, 32'h0, 32'h0});
        acc('{0, 0, 12'h0f0, 4'hf, 32'h0, 32'h0000_000d});
        acc('{0, 0, 12'h0f8, 4'hf, 32'h0, 32'h0});
        idle();
        finish_test();
    end
endmodule

`default_nettype wire
